// *** core/bwcr_pkg.sv ***
// Constants, types and register map of the bridge window configuration bank
package bwcr_pkg;

  // Bus geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;
  localparam int IDX_W  = 8;
  localparam int IDX_LSB = 2;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SEC_STATUS   = 8'h1E;
  localparam logic [IDX_W-1:0] IDX_MEM_BASE     = 8'h20;
  localparam logic [IDX_W-1:0] IDX_MEM_LIMIT    = 8'h22;
  localparam logic [IDX_W-1:0] IDX_PF_BASE      = 8'h24;
  localparam logic [IDX_W-1:0] IDX_PF_LIMIT     = 8'h26;
  localparam logic [IDX_W-1:0] IDX_PF_BASE_UP   = 8'h28;
  localparam logic [IDX_W-1:0] IDX_PF_LIMIT_UP  = 8'h2C;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS   = 8'h40;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR    = 8'h41;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE   = 8'h42;
  localparam logic [IDX_W-1:0] IDX_CONTROL      = 8'h43;

  // Secondary status fields
  localparam int SEL_SPEED_LSB = 9;
  localparam int MDE_BIT       = 8;
  localparam int B2B_BIT       = 7;
  localparam int RSVD6_BIT     = 6;
  localparam int CAP66_BIT     = 5;
  localparam int RSVD_LO_W     = 5;

  // Select response speed encodings
  typedef enum logic [1:0] {
    BWCR_SPEED_FAST   = 2'b00,
    BWCR_SPEED_MEDIUM = 2'b01,
    BWCR_SPEED_SLOW   = 2'b10,
    BWCR_SPEED_RSVD   = 2'b11
  } bwcr_speed_e;

  // Window fields
  localparam int WIN_LSB   = 4;
  localparam int WIN_W     = 12;
  localparam int WIN_GRAN  = 20;
  localparam int UP_LO_W   = 8;
  localparam int UP_HI_W   = 24;
  localparam logic [3:0]  MEM_CAP = 4'h0;
  localparam logic [3:0]  PF_CAP  = 4'h1;
  localparam logic [WIN_W-1:0]    WIN_RST  = 12'h000;
  localparam logic [DATA_W-1:0]   UP_RST   = 32'h0000_0000;
  localparam logic [WIN_GRAN-1:0] GRAN_ZERO = 20'h0_0000;
  localparam logic [WIN_GRAN-1:0] GRAN_ONES = 20'hF_FFFF;

  // Control and interrupt fields
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_PER_BIT = 1;
  localparam int CTRL_W       = 2;
  localparam int IRQ_W        = 1;
  localparam int IRQ_MDE_BIT  = 0;

  // Avalon-MM request from the master
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [BE_W-1:0]   byteenable;
    logic [DATA_W-1:0] writedata;
  } bwcr_avl_req_s;

  // Parity report from the secondary master engine
  typedef struct packed {
    logic mastering;
    logic is_read;
    logic drove_perr;
    logic saw_perr;
  } bwcr_perr_evt_s;

  // Address to decode against the windows
  typedef struct packed {
    logic        valid;
    logic [63:0] addr;
  } bwcr_dec_req_s;

endpackage

// *** core/bwcr_regs.sv ***
// Bridge window configuration register bank with Avalon-MM slave and decode
`timescale 1ns/100ps
`default_nettype none

module bwcr_regs
  import bwcr_pkg::*;
(
  // Clock and warm reset
  input  wire logic           i_core_clk,
  input  wire logic           i_arst_n,
  // Avalon-MM slave
  input  wire bwcr_avl_req_s  i_avl,
  output logic [DATA_W-1:0]   o_readdata,
  output logic                o_waitrequest,
  // Secondary master parity report
  input  wire bwcr_perr_evt_s i_perr,
  // Window decode
  input  wire bwcr_dec_req_s  i_dec,
  output logic                o_mem_hit,
  output logic                o_pref_hit,
  // Mode and interrupt
  output logic                o_extended_bridge_mode,
  output logic                o_irq
);

  // Registers
  logic [WIN_W-1:0]  mem_base_q;
  logic [WIN_W-1:0]  mem_limit_q;
  logic [WIN_W-1:0]  pf_base_q;
  logic [WIN_W-1:0]  pf_limit_q;
  logic [DATA_W-1:0] pf_base_up_q;
  logic [DATA_W-1:0] pf_limit_up_q;
  logic              mde_q;
  logic [IRQ_W-1:0]  irq_status_q;
  logic [IRQ_W-1:0]  irq_enable_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic              wait_q;
  logic [DATA_W-1:0] rdata_q;
  logic              irq_q;
  logic              mem_hit_q;
  logic              pref_hit_q;

  // Byte-lane merge of write data into an old value
  function automatic logic [DATA_W-1:0] lane_merge(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [BE_W-1:0]   be
  );
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int b = 0; b < BE_W; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Address decode and bus handshake terms
  wire logic [IDX_W-1:0] word_idx = i_avl.address[IDX_LSB +: IDX_W];
  wire logic req_new   = (i_avl.read | i_avl.write) & wait_q;
  wire logic wr_ack    = i_avl.write & ~wait_q;
  wire logic rd_ack    = i_avl.read & ~wait_q;
  wire logic sel_stat  = (word_idx == IDX_SEC_STATUS);
  wire logic sel_mb    = (word_idx == IDX_MEM_BASE);
  wire logic sel_ml    = (word_idx == IDX_MEM_LIMIT);
  wire logic sel_pb    = (word_idx == IDX_PF_BASE);
  wire logic sel_pl    = (word_idx == IDX_PF_LIMIT);
  wire logic sel_pbu   = (word_idx == IDX_PF_BASE_UP);
  wire logic sel_plu   = (word_idx == IDX_PF_LIMIT_UP);
  wire logic sel_ist   = (word_idx == IDX_IRQ_STATUS);
  wire logic sel_icl   = (word_idx == IDX_IRQ_CLEAR);
  wire logic sel_ien   = (word_idx == IDX_IRQ_ENABLE);
  wire logic sel_ctl   = (word_idx == IDX_CONTROL);
  wire logic [DATA_W-1:0] wmask = lane_merge('0, {DATA_W{1'b1}}, i_avl.byteenable);
  wire logic [DATA_W-1:0] w1c   = i_avl.writedata & wmask;

  // Mode and parity response enable
  wire logic ext_mode = ctrl_q[CTRL_EXT_BIT];
  wire logic per_en   = ctrl_q[CTRL_PER_BIT];

  // Qualified master data error event
  wire logic perr_hit = (i_perr.is_read & i_perr.drove_perr)
                      | (~i_perr.is_read & i_perr.saw_perr);
  wire logic mde_set  = i_perr.mastering & perr_hit & per_en;
  wire logic mde_clr  = wr_ack & sel_stat & w1c[MDE_BIT];
  wire logic mde_d    = mde_set | (mde_q & ~mde_clr);

  // Interrupt status, set beats clear
  wire logic [IRQ_W-1:0] irq_set  = {IRQ_W{1'b0}} | (IRQ_W'(mde_set) << IRQ_MDE_BIT);
  wire logic [IRQ_W-1:0] irq_clr  = (wr_ack & sel_icl) ? w1c[IRQ_W-1:0] : {IRQ_W{1'b0}};
  wire logic [IRQ_W-1:0] irq_st_d = irq_set | (irq_status_q & ~irq_clr);
  wire logic [DATA_W-1:0] ien_m   = lane_merge({{(DATA_W-IRQ_W){1'b0}}, irq_enable_q},
                                               i_avl.writedata, i_avl.byteenable);
  wire logic [DATA_W-1:0] ctl_m   = lane_merge({{(DATA_W-CTRL_W){1'b0}}, ctrl_q},
                                               i_avl.writedata, i_avl.byteenable);
  wire logic [IRQ_W-1:0] irq_en_d = (wr_ack & sel_ien) ? ien_m[IRQ_W-1:0] : irq_enable_q;
  wire logic [CTRL_W-1:0] ctrl_d  = (wr_ack & sel_ctl) ? ctl_m[CTRL_W-1:0] : ctrl_q;

  // Window base and limit next values, address field only
  wire logic [DATA_W-1:0] wr_mb = lane_merge({16'h0000, mem_base_q, MEM_CAP},
                                             i_avl.writedata, i_avl.byteenable);
  wire logic [DATA_W-1:0] wr_ml = lane_merge({16'h0000, mem_limit_q, MEM_CAP},
                                             i_avl.writedata, i_avl.byteenable);
  wire logic [DATA_W-1:0] wr_pb = lane_merge({16'h0000, pf_base_q, PF_CAP},
                                             i_avl.writedata, i_avl.byteenable);
  wire logic [DATA_W-1:0] wr_pl = lane_merge({16'h0000, pf_limit_q, PF_CAP},
                                             i_avl.writedata, i_avl.byteenable);
  wire logic [WIN_W-1:0] mem_base_d  = (wr_ack & sel_mb) ? wr_mb[WIN_LSB +: WIN_W]
                                                         : mem_base_q;
  wire logic [WIN_W-1:0] mem_limit_d = (wr_ack & sel_ml) ? wr_ml[WIN_LSB +: WIN_W]
                                                         : mem_limit_q;
  wire logic [WIN_W-1:0] pf_base_d   = (wr_ack & sel_pb) ? wr_pb[WIN_LSB +: WIN_W]
                                                         : pf_base_q;
  wire logic [WIN_W-1:0] pf_limit_d  = (wr_ack & sel_pl) ? wr_pl[WIN_LSB +: WIN_W]
                                                         : pf_limit_q;

  // Upper halves; bits 31:8 only take writes in extended mode
  wire logic [DATA_W-1:0] up_keep = {{UP_HI_W{~ext_mode}}, {UP_LO_W{1'b0}}};
  wire logic [DATA_W-1:0] wr_pbu  = lane_merge(pf_base_up_q, i_avl.writedata,
                                               i_avl.byteenable);
  wire logic [DATA_W-1:0] wr_plu  = lane_merge(pf_limit_up_q, i_avl.writedata,
                                               i_avl.byteenable);
  wire logic [DATA_W-1:0] pbu_d   = (wr_ack & sel_pbu) ?
                                    ((wr_pbu & ~up_keep) | (pf_base_up_q & up_keep))
                                    : pf_base_up_q;
  wire logic [DATA_W-1:0] plu_d   = (wr_ack & sel_plu) ?
                                    ((wr_plu & ~up_keep) | (pf_limit_up_q & up_keep))
                                    : pf_limit_up_q;

  // Visible upper values: legacy mode hides bits 31:8
  wire logic [DATA_W-1:0] up_vis  = {{UP_HI_W{ext_mode}}, {UP_LO_W{1'b1}}};
  wire logic [DATA_W-1:0] pbu_eff = pf_base_up_q & up_vis;
  wire logic [DATA_W-1:0] plu_eff = pf_limit_up_q & up_vis;

  // Secondary status image
  wire bwcr_speed_e sel_speed = BWCR_SPEED_MEDIUM;
  wire logic [15:0] sec_status = {5'b0_0000,
                                  sel_speed,
                                  mde_q,
                                  1'b1,
                                  1'b0,
                                  1'b1,
                                  {RSVD_LO_W{1'b0}}};

  // Read data select; unmapped and write-only read zero
  wire logic [DATA_W-1:0] rd_mux =
      sel_stat ? {16'h0000, sec_status} :
      sel_mb   ? {16'h0000, mem_base_q, MEM_CAP} :
      sel_ml   ? {16'h0000, mem_limit_q, MEM_CAP} :
      sel_pb   ? {16'h0000, pf_base_q, PF_CAP} :
      sel_pl   ? {16'h0000, pf_limit_q, PF_CAP} :
      sel_pbu  ? pbu_eff :
      sel_plu  ? plu_eff :
      sel_ist  ? {{(DATA_W-IRQ_W){1'b0}}, irq_status_q} :
      sel_ien  ? {{(DATA_W-IRQ_W){1'b0}}, irq_enable_q} :
      sel_ctl  ? {{(DATA_W-CTRL_W){1'b0}}, ctrl_q} :
                 32'h0000_0000;

  // Window decode, unprogrammed low bits zero in base, ones in limit
  wire logic [63:0] mem_lo_a = {32'h0000_0000, mem_base_q, GRAN_ZERO};
  wire logic [63:0] mem_hi_a = {32'h0000_0000, mem_limit_q, GRAN_ONES};
  wire logic [63:0] pf_lo_a  = {pbu_eff, pf_base_q, GRAN_ZERO};
  wire logic [63:0] pf_hi_a  = {plu_eff, pf_limit_q, GRAN_ONES};
  wire logic mem_in = i_dec.valid & (i_dec.addr >= mem_lo_a)
                    & (i_dec.addr <= mem_hi_a);
  wire logic pf_in  = i_dec.valid & (i_dec.addr >= pf_lo_a)
                    & (i_dec.addr <= pf_hi_a);

  // Bus handshake: one wait cycle, then one ready cycle
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= ~req_new;
      if (req_new) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Window registers, cleared by warm reset
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mem_base_q    <= WIN_RST;
      mem_limit_q   <= WIN_RST;
      pf_base_q     <= WIN_RST;
      pf_limit_q    <= WIN_RST;
      pf_base_up_q  <= UP_RST;
      pf_limit_up_q <= UP_RST;
    end else begin
      mem_base_q    <= mem_base_d;
      mem_limit_q   <= mem_limit_d;
      pf_base_q     <= pf_base_d;
      pf_limit_q    <= pf_limit_d;
      pf_base_up_q  <= pbu_d;
      pf_limit_up_q <= plu_d;
    end
  end

  // Error flag, interrupt and control
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mde_q        <= 1'b0;
      irq_status_q <= '0;
      irq_enable_q <= '0;
      ctrl_q       <= '0;
      irq_q        <= 1'b0;
    end else begin
      mde_q        <= mde_d;
      irq_status_q <= irq_st_d;
      irq_enable_q <= irq_en_d;
      ctrl_q       <= ctrl_d;
      irq_q        <= |(irq_st_d & irq_en_d);
    end
  end

  // Registered decode results
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mem_hit_q  <= 1'b0;
      pref_hit_q <= 1'b0;
    end else begin
      mem_hit_q  <= mem_in;
      pref_hit_q <= pf_in;
    end
  end

  // Outputs
  assign o_readdata             = rdata_q;
  assign o_waitrequest          = wait_q;
  assign o_mem_hit              = mem_hit_q;
  assign o_pref_hit             = pref_hit_q;
  assign o_extended_bridge_mode = ctrl_q[CTRL_EXT_BIT];
  assign o_irq                  = irq_q;

  // Checks
  sequence s_req_wait;
    (i_avl.read | i_avl.write) & o_waitrequest;
  endsequence

  sequence s_ack_then_idle;
    !o_waitrequest ##1 o_waitrequest;
  endsequence

  bus_handshake_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    s_req_wait |=> s_ack_then_idle)
    else $error("ack did not follow a waited request");

  speed_medium_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    rd_ack & sel_stat |-> o_readdata[SEL_SPEED_LSB +: 2] == 2'b01)
    else $error("select speed not medium");

  mde_set_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    mde_set |=> mde_q ##0 irq_status_q[IRQ_MDE_BIT])
    else $error("error flag not set by event");

  mde_cause_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    $rose(mde_q) |-> $past(i_perr.mastering) & $past(per_en))
    else $error("error flag set without cause");

  mde_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    wr_ack & sel_stat & w1c[MDE_BIT] & !mde_set |=> !mde_q)
    else $error("error flag not cleared by one");

  cap_bits_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    rd_ack & sel_stat |-> o_readdata[B2B_BIT] & o_readdata[CAP66_BIT])
    else $error("capability bits not one");

  status_rsvd_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    rd_ack & sel_stat |-> !o_readdata[RSVD6_BIT] && o_readdata[4:0] == 5'b0_0000)
    else $error("reserved status bits not zero");

  mem_cap_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    rd_ack & (sel_mb | sel_ml) |-> o_readdata[3:0] == MEM_CAP)
    else $error("memory window low nibble not zero");

  pf_cap_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    rd_ack & (sel_pb | sel_pl) |-> o_readdata[3:0] == PF_CAP)
    else $error("prefetch window low nibble not one");

  base_write_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    wr_ack & sel_mb & (i_avl.byteenable[1:0] == 2'b11)
    |=> mem_base_q == $past(i_avl.writedata[WIN_LSB +: WIN_W]))
    else $error("memory base write lost");

  up_legacy_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    rd_ack & (sel_pbu | sel_plu) & !ext_mode |-> o_readdata[31:8] == 24'h00_0000)
    else $error("upper bits visible in legacy mode");

  mem_hit_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_dec.valid && i_dec.addr == mem_hi_a && mem_base_q <= mem_limit_q |=> o_mem_hit)
    else $error("inclusive memory limit missed");

  cap66_bit_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    rd_ack & sel_stat |-> o_readdata[CAP66_BIT])
    else $error("66 MHz capable bit not one");

  limit_write_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    wr_ack & sel_ml & (i_avl.byteenable[1:0] == 2'b11)
    |=> mem_limit_q == $past(i_avl.writedata[WIN_LSB +: WIN_W]))
    else $error("memory limit write lost");

  pf_base_write_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    wr_ack & sel_pb & (i_avl.byteenable[1:0] == 2'b11)
    |=> pf_base_q == $past(i_avl.writedata[WIN_LSB +: WIN_W]))
    else $error("prefetch base write lost");

  pf_limit_write_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    wr_ack & sel_pl & (i_avl.byteenable[1:0] == 2'b11)
    |=> pf_limit_q == $past(i_avl.writedata[WIN_LSB +: WIN_W]))
    else $error("prefetch limit write lost");

  up_base_low_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    wr_ack & sel_pbu & i_avl.byteenable[0]
    |=> pf_base_up_q[UP_LO_W-1:0] == $past(i_avl.writedata[UP_LO_W-1:0]))
    else $error("upper base low byte write lost");

  up_limit_low_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    wr_ack & sel_plu & i_avl.byteenable[0]
    |=> pf_limit_up_q[UP_LO_W-1:0] == $past(i_avl.writedata[UP_LO_W-1:0]))
    else $error("upper limit low byte write lost");

  up_ext_write_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    wr_ack & sel_pbu & ext_mode & (i_avl.byteenable == 4'hF)
    |=> pf_base_up_q == $past(i_avl.writedata))
    else $error("upper base not writable in extended mode");

  up_legacy_keep_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    wr_ack & (sel_pbu | sel_plu) & !ext_mode
    |=> $stable(pf_base_up_q[DATA_W-1:UP_LO_W]) && $stable(pf_limit_up_q[DATA_W-1:UP_LO_W]))
    else $error("upper bits written in legacy mode");

  reset_windows_a: assert property (@(posedge i_core_clk)
    $rose(i_arst_n) |-> mem_base_q == WIN_RST && mem_limit_q == WIN_RST
                        && pf_base_q == WIN_RST && pf_limit_q == WIN_RST
                        && pf_base_up_q == UP_RST && pf_limit_up_q == UP_RST && !mde_q)
    else $error("window fields not cleared by reset");

  reset_outputs_a: assert property (@(posedge i_core_clk)
    $rose(i_arst_n) |-> o_waitrequest && !o_irq && !o_mem_hit && !o_pref_hit
                        && !o_extended_bridge_mode)
    else $error("outputs not idle after reset");

  dec_idle_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !i_dec.valid |=> !o_mem_hit && !o_pref_hit)
    else $error("hit without a decode request");

  pf_hit_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_dec.valid && i_dec.addr == pf_hi_a && pf_lo_a <= pf_hi_a |=> o_pref_hit)
    else $error("inclusive prefetch limit missed");

  clear_read_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    rd_ack & sel_icl |-> o_readdata == 32'h0000_0000)
    else $error("interrupt clear register not reading zero");

  mde_keep_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    wr_ack & sel_stat & !w1c[MDE_BIT] & mde_q |=> mde_q)
    else $error("error flag cleared by a zero");

  irq_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    wr_ack & sel_icl & w1c[IRQ_MDE_BIT] & !mde_set |=> !irq_status_q[IRQ_MDE_BIT])
    else $error("interrupt status not cleared by one");

endmodule

`default_nettype wire

// *** tb/bwcr_regs_test.sv ***
// Self-checking testbench of the bridge window configuration bank
`timescale 1ns/100ps
`default_nettype none

module bwcr_regs_test
  import bwcr_pkg::*;
;
  // Window registers with reset and all-ones-written values (legacy mode)
  localparam logic [IDX_W-1:0] WIN_IX [6] = '{IDX_MEM_BASE, IDX_MEM_LIMIT, IDX_PF_BASE,
                                              IDX_PF_LIMIT, IDX_PF_BASE_UP, IDX_PF_LIMIT_UP};
  localparam logic [31:0] RST_V [6] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0001,
                                        32'h0000_0001, 32'h0000_0000, 32'h0000_0000};
  localparam logic [31:0] ONE_V [6] = '{32'h0000_FFF0, 32'h0000_FFF0, 32'h0000_FFF1,
                                        32'h0000_FFF1, 32'h0000_00FF, 32'h0000_00FF};
  // Probes {address, memory hit, prefetch hit}, extended mode
  localparam logic [65:0] PRB [10] = '{
    {64'h0000_0000_1230_0000, 2'h2}, {64'h0000_0000_122F_FFFF, 2'h0},
    {64'h0000_0000_124F_FFFF, 2'h2}, {64'h0000_0000_1250_0000, 2'h0},
    {64'h0000_0001_1230_0000, 2'h0}, {64'hABCD_EF01_0100_0000, 2'h1},
    {64'hABCD_EF01_00FF_FFFF, 2'h0}, {64'hABCD_EF02_020F_FFFF, 2'h1},
    {64'hABCD_EF02_0210_0000, 2'h0}, {64'hABCD_EF01_FFFF_FFFF, 2'h1}};
  // Parity events {mastering, is_read, drove, saw, flag expected}
  localparam logic [4:0] EVT [5] = '{5'h1D, 5'h1A, 5'h13, 5'h14, 5'h0C};
  localparam logic [31:0] STAT_V = 32'h0000_02A0;

  logic           clk;
  logic           arst_n;
  bwcr_avl_req_s  avl;
  logic [31:0]    rdata;
  logic           wait_req;
  bwcr_perr_evt_s perr;
  bwcr_dec_req_s  dec;
  logic           mem_hit;
  logic           pf_hit;
  logic           ext_mode;
  logic           irq;
  int             err_total;
  int             checks_done;

  // Design and far-side agent
  bwcr_regs bwcr_regs_inst (
    .i_core_clk             (clk),
    .i_arst_n               (arst_n),
    .i_avl                  (avl),
    .o_readdata             (rdata),
    .o_waitrequest          (wait_req),
    .i_perr                 (perr),
    .i_dec                  (dec),
    .o_mem_hit              (mem_hit),
    .o_pref_hit             (pf_hit),
    .o_extended_bridge_mode (ext_mode),
    .o_irq                  (irq)
  );
  bwcr_sec_agent bwcr_sec_agent_inst (
    .i_core_clk (clk),
    .o_perr     (perr),
    .o_dec      (dec)
  );

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compare and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    chk({31'h0000_0000, seen}, {31'h0000_0000, exp});
  endtask

  // One Avalon-MM access, held until waitrequest is sampled low
  task automatic xfer(input logic rw, input logic [IDX_W-1:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    avl <= '{read: !rw, write: rw, address: {idx, 2'b00}, byteenable: 4'hF, writedata: wd};
    // Waitrequest sampled at each rising edge; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (wait_req !== 1'b0);
    rd = rdata;
    avl <= '0;
    chk1(wait_req, 1'b0);
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] wd);
    logic [31:0] dummy;
    xfer(1'b1, idx, wd, dummy);
  endtask

  task automatic rdchk(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    xfer(1'b0, idx, 32'h0000_0000, d);
    chk(d, exp);
  endtask

  // Decode one address and look at both hits a cycle later
  task automatic pr(input logic [65:0] p);
    bwcr_sec_agent_inst.probe(p[65:2]);
    @(negedge clk);
    chk1(mem_hit, p[1]);
    chk1(pf_hit, p[0]);
  endtask

  // Interrupt output one cycle after its cause
  task automatic irq_is(input logic exp);
    @(posedge clk);
    @(negedge clk);
    chk1(irq, exp);
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end

  // Test sequence
  initial begin
    err_total = 0;
    checks_done = 0;
    avl = '0;
    arst_n = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    rdchk(IDX_SEC_STATUS, STAT_V);
    wr(IDX_SEC_STATUS, 32'hFFFF_FEFF);
    rdchk(IDX_SEC_STATUS, STAT_V);
    for (int i = 0; i < 6; i++) begin
      rdchk(WIN_IX[i], RST_V[i]);
      wr(WIN_IX[i], 32'hFFFF_FFFF);
      rdchk(WIN_IX[i], ONE_V[i]);
    end
    rdchk(8'h30, 32'h0000_0000);
    // Extended mode opens the upper address bits
    wr(IDX_CONTROL, 32'h0000_0001);
    @(negedge clk);
    chk1(ext_mode, 1'b1);
    wr(IDX_PF_BASE_UP, 32'hABCD_EF01);
    wr(IDX_PF_LIMIT_UP, 32'hABCD_EF02);
    rdchk(IDX_PF_BASE_UP, 32'hABCD_EF01);
    rdchk(IDX_PF_LIMIT_UP, 32'hABCD_EF02);
    wr(IDX_MEM_BASE, 32'h0000_1230);
    wr(IDX_MEM_LIMIT, 32'h0000_1240);
    wr(IDX_PF_BASE, 32'h0000_0100);
    wr(IDX_PF_LIMIT, 32'h0000_0200);
    rdchk(IDX_PF_LIMIT, 32'h0000_0201);
    for (int i = 0; i < 10; i++) begin
      pr(PRB[i]);
    end
    // Back to legacy: upper bits read and decode as zero
    wr(IDX_CONTROL, 32'h0000_0000);
    rdchk(IDX_PF_BASE_UP, 32'h0000_0001);
    pr({64'h0000_0001_0100_0000, 2'h1});
    pr({64'hABCD_EF01_0100_0000, 2'h0});
    // Parity events ignored while response is disabled
    bwcr_sec_agent_inst.fire(4'hE);
    rdchk(IDX_SEC_STATUS, STAT_V);
    wr(IDX_CONTROL, 32'h0000_0002);
    for (int i = 0; i < 5; i++) begin
      bwcr_sec_agent_inst.fire(EVT[i][4:1]);
      rdchk(IDX_SEC_STATUS, STAT_V | {23'h00_0000, EVT[i][0], 8'h00});
      wr(IDX_SEC_STATUS, 32'h0000_0000);
      rdchk(IDX_SEC_STATUS, STAT_V | {23'h00_0000, EVT[i][0], 8'h00});
      wr(IDX_SEC_STATUS, 32'h0000_0100);
      rdchk(IDX_SEC_STATUS, STAT_V);
    end
    // Interrupt masked, enabled, cleared, raised again
    irq_is(1'b0);
    rdchk(IDX_IRQ_STATUS, 32'h0000_0001);
    wr(IDX_IRQ_ENABLE, 32'h0000_0001);
    irq_is(1'b1);
    rdchk(IDX_IRQ_CLEAR, 32'h0000_0000);
    wr(IDX_IRQ_CLEAR, 32'h0000_0001);
    irq_is(1'b0);
    rdchk(IDX_IRQ_STATUS, 32'h0000_0000);
    bwcr_sec_agent_inst.fire(4'h9);
    irq_is(1'b1);
    // Warm reset in mid-run clears flag and windows
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk1(irq, 1'b0);
    rdchk(IDX_SEC_STATUS, STAT_V);
    for (int i = 0; i < 6; i++) begin
      rdchk(WIN_IX[i], RST_V[i]);
    end
    wrap_up();
  end

endmodule

`default_nettype wire

// *** tb/bwcr_sec_agent.sv ***
// Secondary bus agent model: parity reports and addresses to decode
`timescale 1ns/100ps
`default_nettype none

module bwcr_sec_agent
  import bwcr_pkg::*;
(
  // Clock
  input  wire logic          i_core_clk,
  // Toward the register bank
  output var bwcr_perr_evt_s o_perr,
  output var bwcr_dec_req_s  o_dec
);

  // Idle at time zero, filler address of repeated A5 bytes on the lines
  initial begin
    o_perr = '0;
    o_dec  = '{valid: 1'b0, addr: 64'hA5A5_A5A5_A5A5_A5A5};
  end

  // One-cycle parity report {mastering, is_read, drove, saw}
  task automatic fire(input logic [3:0] ev);
    @(posedge i_core_clk);
    o_perr <= ev;
    @(posedge i_core_clk);
    o_perr <= '0;
  endtask

  // One-cycle decode request; released address shows its inverse
  task automatic probe(input logic [63:0] a);
    @(posedge i_core_clk);
    o_dec <= '{valid: 1'b1, addr: a};
    @(posedge i_core_clk);
    o_dec <= '{valid: 1'b0, addr: ~a};
  endtask

endmodule

`default_nettype wire
